// >>> hdl/hawg_pkg.sv
package hawg_pkg;
    // Port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CLK_MHZ = 50;

    // Register byte offsets on the host port
    localparam logic [7:0] OFS_RX_DATA = 8'h00;
    localparam logic [7:0] OFS_TX_DATA = 8'h20;
    localparam logic [7:0] OFS_RX_STAT = 8'h40;
    localparam logic [7:0] OFS_TX_STAT = 8'h48;
    localparam logic [7:0] OFS_IDENT = 8'h50;
    localparam logic [7:0] OFS_IRQ_CFG = 8'h54;
    localparam logic [7:0] OFS_INT_STAT = 8'h58;
    localparam logic [7:0] OFS_INT_EN = 8'h5C;
    localparam logic [7:0] OFS_BYTE_TEST = 8'h64;
    localparam logic [7:0] OFS_FIFO_INT = 8'h68;
    localparam logic [7:0] OFS_RX_CFG = 8'h6C;
    localparam logic [7:0] OFS_TX_CFG = 8'h70;
    localparam logic [7:0] OFS_HARDWARE_CONFIG_REG = 8'h74;
    localparam logic [7:0] OFS_RX_DP = 8'h78;
    localparam logic [7:0] OFS_RX_INFO = 8'h7C;
    localparam logic [7:0] OFS_TX_INFO = 8'h80;
    localparam logic [7:0] OFS_PWR_CTRL = 8'h84;
    localparam logic [7:0] OFS_PIO_CFG = 8'h88;
    localparam logic [7:0] OFS_TMR_CFG = 8'h8C;
    localparam logic [7:0] OFS_TMR_CNT = 8'h90;
    localparam logic [7:0] OFS_HALF_ORD = 8'h98;
    localparam logic [7:0] OFS_FREE_CNT = 8'h9C;
    localparam logic [7:0] OFS_RX_DISC = 8'hA0;
    localparam logic [7:0] OFS_MAC_CMD = 8'hA4;
    localparam logic [7:0] OFS_MAC_DATA = 8'hA8;
    localparam logic [7:0] OFS_FLOW_CFG = 8'hAC;
    localparam logic [7:0] OFS_EE_CMD = 8'hB0;
    localparam logic [7:0] OFS_EE_DATA = 8'hB4;

    // Fixed read values; the identity value is arbitrary
    localparam logic [15:0] BYTE_TEST_VAL = 16'h4321;
    localparam logic [15:0] IDENT_VAL = 16'h0A5C;

    // Minimum waits in ns, and least cycle counts rounded up
    localparam int WAIT_1_NS = 45;
    localparam int WAIT_2_NS = 90;
    localparam int WAIT_3_NS = 135;
    localparam int WAIT_4_NS = 180;
    localparam int WAIT_7_NS = 315;
    localparam int WAIT_1_CYC = (WAIT_1_NS * CLK_MHZ + 999) / 1000;
    localparam int WAIT_2_CYC = (WAIT_2_NS * CLK_MHZ + 999) / 1000;
    localparam int WAIT_3_CYC = (WAIT_3_NS * CLK_MHZ + 999) / 1000;
    localparam int WAIT_4_CYC = (WAIT_4_NS * CLK_MHZ + 999) / 1000;
    localparam int WAIT_7_CYC = (WAIT_7_NS * CLK_MHZ + 999) / 1000;

    // Longest device lag before side effects show, rounded down
    localparam int TX_LAG_CYC = (WAIT_3_NS * CLK_MHZ) / 1000;
    localparam int DISC_LAG_CYC = (WAIT_4_NS * CLK_MHZ) / 1000;

    // Strobe low and high minima
    localparam int STROBE_LOW_NS = 32;
    localparam int STROBE_HIGH_NS = 13;
    localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
endpackage : hawg_pkg

// >>> hdl/hawg_if.sv
`timescale 1ns/1ps
interface hawg_if;
    logic        chip_select_n;
    logic        read_strobe_n;
    logic        write_strobe_n;
    logic        fifo_select;
    logic [7:0]  addr;
    logic [15:0] host_data;
    logic        host_data_oe;
    logic [15:0] dev_data;
    logic        dev_data_oe;
    logic [15:0] data_bus;

    // Shared data wire; undriven bus reads as pulled high
    assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 16'hFFFF);

    modport host (
        output chip_select_n, read_strobe_n, write_strobe_n, fifo_select, addr,
        output host_data, host_data_oe,
        input  data_bus
    );
    modport device (
        input  chip_select_n, read_strobe_n, write_strobe_n, fifo_select, addr,
        input  data_bus,
        output dev_data, dev_data_oe
    );
endinterface : hawg_if

// >>> hdl/hawg_device_end.sv
`timescale 1ns/1ps
module hawg_device_end #(
    parameter int TX_LAG   = hawg_pkg::TX_LAG_CYC,
    parameter int DISC_LAG = hawg_pkg::DISC_LAG_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    // Host port pins
    hawg_if.device           bus,
    // Receive side of the data path
    input  wire logic        rx_push_in,
    input  wire logic [15:0] rx_word_in,
    input  wire logic [15:0] rx_status_in,
    input  wire logic        rx_discard_in,
    output logic             rx_pop_out,
    output logic             rx_status_pop_out,
    // Transmit side of the data path
    output logic             tx_word_valid_out,
    output logic [15:0]      tx_word_out,
    input  wire logic        tx_drain_in,
    input  wire logic        tx_status_push_in,
    input  wire logic [15:0] tx_status_in
);
    localparam int SW = 28;
    localparam int FS = 24;                          // FIFO select bit in the sample word

    logic [SW-1:0] s1_q, s2_q, s3_q;
    logic [2:0]    strb_q;
    logic          rd_act_q, wr_act_q;
    logic [7:0]    wr_addr_q;
    logic [15:0]   wr_data_q;
    logic [15:0]   ctrl_q [0:63];
    logic [7:0]    tx_level_q, tx_stat_q, rx_level_q;
    logic [15:0]   disc_q;
    logic [TX_LAG-1:0]   tx_sr_q, rxp_sr_q, txs_sr_q;
    logic [DISC_LAG-1:0] disc_sr_q;
    logic [15:0]   rd_word;
    logic          rd_act, wr_act, rd_start, wr_end;
    logic          pop_rx, pop_rxs, pop_txs, rd_disc, push_tx;

    ////////////////////////////////////////////////////////////////////////
    // Three-stage pin sampling; a strobe counts once stages two and three agree
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_q <= 28'hFFFFFFF;
            s2_q <= 28'hFFFFFFF;
            s3_q <= 28'hFFFFFFF;
        end else begin
            s1_q <= {bus.chip_select_n, bus.read_strobe_n, bus.write_strobe_n,
                     bus.fifo_select, bus.addr, bus.data_bus};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            strb_q <= 3'h7;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (s2_q[SW-1-i] == s3_q[SW-1-i]) strb_q[2-i] <= s3_q[SW-1-i];
            end
        end
    end

    // Cycle runs while chip select and its strobe are both low, ends when either rises
    assign rd_act   = !strb_q[2] && !strb_q[1];
    assign wr_act   = !strb_q[2] && !strb_q[0];
    assign rd_start = rd_act && !rd_act_q;
    assign wr_end   = wr_act_q && !wr_act;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode; FIFO select overrides the whole address
    always_comb begin
        rd_word = 16'h0000;
        if (s3_q[FS]) begin
            rd_word = rx_word_in;
        end else begin
            unique case (s3_q[23:16])
                hawg_pkg::OFS_RX_DATA:  rd_word = rx_word_in;
                hawg_pkg::OFS_RX_STAT:  rd_word = rx_status_in;
                hawg_pkg::OFS_TX_STAT:  rd_word = tx_status_in;
                hawg_pkg::OFS_IDENT:    rd_word = hawg_pkg::IDENT_VAL;
                hawg_pkg::OFS_BYTE_TEST: rd_word = hawg_pkg::BYTE_TEST_VAL;
                hawg_pkg::OFS_RX_INFO:  rd_word = {8'h00, rx_level_q};
                hawg_pkg::OFS_TX_INFO:  rd_word = {tx_stat_q, tx_level_q};
                hawg_pkg::OFS_RX_DISC:  rd_word = disc_q;
                default:                rd_word = ctrl_q[s3_q[23:18]];
            endcase
        end
    end

    // Side-effect reads, judged once at the start of each cycle; the transmit push at the end of a write
    assign pop_rx  = rd_start && (s3_q[FS] || s3_q[23:16] == hawg_pkg::OFS_RX_DATA);
    assign pop_rxs = rd_start && !s3_q[FS] && s3_q[23:16] == hawg_pkg::OFS_RX_STAT;
    assign pop_txs = rd_start && !s3_q[FS] && s3_q[23:16] == hawg_pkg::OFS_TX_STAT;
    assign rd_disc = rd_start && !s3_q[FS] && s3_q[23:16] == hawg_pkg::OFS_RX_DISC;
    assign push_tx = wr_end && wr_addr_q == hawg_pkg::OFS_TX_DATA;

    // Data follows the address every cycle, so bursts need no restart
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus.dev_data    <= 16'h0000;
            bus.dev_data_oe <= 1'b0;
        end else begin
            bus.dev_data    <= rd_word;
            bus.dev_data_oe <= rd_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write capture while active, commit when the cycle ends
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_addr_q <= 8'h00;
            wr_data_q <= 16'h0000;
        end else if (wr_act && !s3_q[SW-1] && !s3_q[SW-3]) begin   // Host data gone once released
            wr_addr_q <= s3_q[23:16];
            wr_data_q <= s3_q[15:0];
        end
    end

    // Plain control words; no reset so the array maps to memory
    always_ff @(posedge ref_clk_in) begin
        if (wr_end && !push_tx) ctrl_q[wr_addr_q[7:2]] <= wr_data_q;
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_word_valid_out <= 1'b0;
            tx_word_out       <= 16'h0000;
            rx_pop_out        <= 1'b0;
            rx_status_pop_out <= 1'b0;
        end else begin
            tx_word_valid_out <= push_tx;
            if (push_tx) tx_word_out <= wr_data_q;
            rx_pop_out        <= pop_rx;
            rx_status_pop_out <= pop_rxs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lag lines: status counts change only after the documented delay
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_sr_q   <= '0;
            rxp_sr_q  <= '0;
            txs_sr_q  <= '0;
            disc_sr_q <= '0;
        end else begin
            tx_sr_q   <= {tx_sr_q[TX_LAG-2:0], push_tx};
            rxp_sr_q  <= {rxp_sr_q[TX_LAG-2:0], pop_rx || pop_rxs};
            txs_sr_q  <= {txs_sr_q[TX_LAG-2:0], pop_txs};
            disc_sr_q <= {disc_sr_q[DISC_LAG-2:0], rd_disc};
        end
    end

    // Level counters; a same-cycle increment survives a clear
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_level_q <= 8'h00;
            tx_stat_q  <= 8'h00;
            rx_level_q <= 8'h00;
            disc_q     <= 16'h0000;
        end else begin
            tx_level_q <= tx_level_q + 8'(tx_sr_q[TX_LAG-1]) - 8'(tx_drain_in);
            tx_stat_q  <= tx_stat_q + 8'(tx_status_push_in) - 8'(txs_sr_q[TX_LAG-1]);
            rx_level_q <= rx_level_q + 8'(rx_push_in) - 8'(rxp_sr_q[TX_LAG-1]);
            if (disc_sr_q[DISC_LAG-1]) disc_q <= 16'(rx_discard_in);
            else                       disc_q <= disc_q + 16'(rx_discard_in);
        end
    end
endmodule : hawg_device_end

// >>> hdl/hawg_host_end.sv
`timescale 1ns/1ps
module hawg_host_end #(
    parameter int RD_LOW_CYC = 10,
    parameter int WR_LOW_CYC = 5,
    parameter int HIGH_CYC   = 4
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    // Host port pins
    hawg_if.host             bus,
    // Command from the user
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic        cmd_fifo_in,
    input  wire logic [7:0]  cmd_addr_in,
    input  wire logic [15:0] cmd_wdata_in,
    output logic             cmd_ready_out,
    // Answer to the user
    output logic             rsp_valid_out,
    output logic [15:0]      rsp_data_out,
    output logic             guard_stall_out
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_GUARD = 4'b0010,
        ST_LOW   = 4'b0100,
        ST_HIGH  = 4'b1000
    } hawg_state_e;

    localparam logic [4:0] W0 = 5'h00;
    localparam logic [4:0] W1 = 5'(hawg_pkg::WAIT_1_CYC);
    localparam logic [4:0] W2 = 5'(hawg_pkg::WAIT_2_CYC);
    localparam logic [4:0] W3 = 5'(hawg_pkg::WAIT_3_CYC);
    localparam logic [4:0] W4 = 5'(hawg_pkg::WAIT_4_CYC);
    localparam logic [4:0] W7 = 5'(hawg_pkg::WAIT_7_CYC);
    localparam logic [4:0] SAT = 5'h1F;
    localparam logic [4:0] RD_LOW = 5'(RD_LOW_CYC);
    localparam logic [4:0] WR_LOW = 5'(WR_LOW_CYC);
    localparam logic [4:0] HIGH = 5'(HIGH_CYC);

    hawg_state_e state_q;
    logic [4:0]  tmr_q;
    logic [4:0]  elapsed_q;
    logic [4:0]  need_d;
    logic [4:0]  need_q;
    logic        last_wr_q;
    logic        last_fifo_q;
    logic [7:0]  last_addr_q;
    logic        cur_wr_q;
    logic [15:0] d1_q, d2_q, d3_q;

    ////////////////////////////////////////////////////////////////////////
    // Wait before a read that follows any write, by target
    function automatic logic [4:0] raw_wait(input logic fifo, input logic [7:0] a);
        logic [4:0] w;
        w = W7;
        if (!fifo) begin
            unique case (a)
                hawg_pkg::OFS_IDENT, hawg_pkg::OFS_BYTE_TEST,
                hawg_pkg::OFS_RX_INFO, hawg_pkg::OFS_RX_DISC:
                    w = W0;
                hawg_pkg::OFS_INT_EN, hawg_pkg::OFS_FIFO_INT, hawg_pkg::OFS_RX_CFG,
                hawg_pkg::OFS_TX_CFG, hawg_pkg::OFS_HARDWARE_CONFIG_REG, hawg_pkg::OFS_RX_DP,
                hawg_pkg::OFS_PIO_CFG, hawg_pkg::OFS_TMR_CFG, hawg_pkg::OFS_HALF_ORD,
                hawg_pkg::OFS_MAC_CMD, hawg_pkg::OFS_MAC_DATA, hawg_pkg::OFS_FLOW_CFG,
                hawg_pkg::OFS_EE_CMD, hawg_pkg::OFS_EE_DATA:
                    w = W1;
                hawg_pkg::OFS_IRQ_CFG, hawg_pkg::OFS_TX_INFO, hawg_pkg::OFS_TMR_CNT:
                    w = W3;
                hawg_pkg::OFS_INT_STAT:
                    w = W2;
                hawg_pkg::OFS_PWR_CTRL:
                    w = W7;
                hawg_pkg::OFS_FREE_CNT:
                    w = W4;
                default:
                    w = W7;
            endcase
        end
        return w;
    endfunction : raw_wait

    // Wait before a read that follows a side-effect read
    function automatic logic [4:0] rar_wait(input logic lfifo, input logic [7:0] la,
                                            input logic fifo, input logic [7:0] a);
        logic [4:0] w;
        logic       last_rx;
        w = W0;
        last_rx = lfifo || la == hawg_pkg::OFS_RX_DATA || la == hawg_pkg::OFS_RX_STAT;
        if (!fifo) begin
            if (last_rx && a == hawg_pkg::OFS_RX_INFO) begin
                w = W3;
            end else if (!lfifo && la == hawg_pkg::OFS_TX_STAT
                         && a == hawg_pkg::OFS_TX_INFO) begin
                w = W3;
            end else if (!lfifo && la == hawg_pkg::OFS_RX_DISC
                         && a == hawg_pkg::OFS_RX_DISC) begin
                w = W4;
            end
        end
        return w;
    endfunction : rar_wait

    // Writes never wait; reads wait by what came last
    always_comb begin
        need_d = W0;
        if (!cmd_write_in) begin
            if (last_wr_q) need_d = raw_wait(cmd_fifo_in, cmd_addr_in);
            else need_d = rar_wait(last_fifo_q, last_addr_q, cmd_fifo_in, cmd_addr_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time since the last cycle ended; dummy reads and slow cycles all count
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            elapsed_q <= SAT;
        end else if (state_q == ST_LOW) begin
            elapsed_q <= W0;
        end else if (elapsed_q != SAT) begin
            elapsed_q <= elapsed_q + 5'h01;
        end
    end

    // Record kind and target of each access on its last strobe-low cycle
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_wr_q   <= 1'b0;
            last_fifo_q <= 1'b0;
            last_addr_q <= 8'h00;
        end else if (state_q == ST_LOW && tmr_q == 5'h01) begin
            last_wr_q   <= cur_wr_q;
            last_fifo_q <= bus.fifo_select;
            last_addr_q <= bus.addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q       <= ST_IDLE;
            tmr_q         <= W0;
            need_q        <= W0;
            cur_wr_q      <= 1'b0;
            cmd_ready_out <= 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (cmd_valid_in && cmd_ready_out) begin
                        need_q        <= need_d;
                        cur_wr_q      <= cmd_write_in;
                        cmd_ready_out <= 1'b0;
                        state_q       <= ST_GUARD;
                    end
                end
                ST_GUARD: begin
                    if (elapsed_q >= need_q) begin
                        tmr_q   <= cur_wr_q ? WR_LOW : RD_LOW;
                        state_q <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (tmr_q == 5'h01) begin
                        tmr_q   <= HIGH;
                        state_q <= ST_HIGH;
                    end else begin
                        tmr_q <= tmr_q - 5'h01;
                    end
                end
                ST_HIGH: begin
                    if (tmr_q == 5'h01) begin
                        cmd_ready_out <= 1'b1;
                        state_q       <= ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 5'h01;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive; address and data held until the next command
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus.chip_select_n  <= 1'b1;
            bus.read_strobe_n  <= 1'b1;
            bus.write_strobe_n <= 1'b1;
            bus.fifo_select    <= 1'b0;
            bus.addr           <= 8'h00;
            bus.host_data      <= 16'h0000;
            bus.host_data_oe   <= 1'b0;
        end else begin
            if (state_q == ST_IDLE && cmd_valid_in && cmd_ready_out) begin
                bus.fifo_select <= cmd_fifo_in && !cmd_write_in;
                bus.addr        <= cmd_addr_in;
                bus.host_data   <= cmd_wdata_in;
            end
            if (state_q == ST_GUARD && elapsed_q >= need_q) begin
                bus.chip_select_n  <= 1'b0;
                bus.read_strobe_n  <= cur_wr_q;
                bus.write_strobe_n <= !cur_wr_q;
                bus.host_data_oe   <= cur_wr_q;
            end else if (state_q == ST_LOW && tmr_q == 5'h01) begin
                bus.chip_select_n  <= 1'b1;
                bus.read_strobe_n  <= 1'b1;
                bus.write_strobe_n <= 1'b1;
                bus.host_data_oe   <= 1'b0;
            end
        end
    end

    // Read data comes from outside, so it passes three stages first
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            d1_q <= 16'h0000;
            d2_q <= 16'h0000;
            d3_q <= 16'h0000;
        end else begin
            d1_q <= bus.data_bus;
            d2_q <= d1_q;
            d3_q <= d2_q;
        end
    end

    // Answer on the last low cycle of a read
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rsp_valid_out   <= 1'b0;
            rsp_data_out    <= 16'h0000;
            guard_stall_out <= 1'b0;
        end else begin
            rsp_valid_out   <= state_q == ST_LOW && tmr_q == 5'h01 && !cur_wr_q;
            if (state_q == ST_LOW && tmr_q == 5'h01 && !cur_wr_q) rsp_data_out <= d3_q;
            guard_stall_out <= state_q == ST_GUARD && elapsed_q < need_q;
        end
    end
endmodule : hawg_host_end

// >>> verification/hawg_checker.sv
`timescale 1ns/1ps
module hawg_checker (
    // Clock, reset and pins
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        chip_select_n,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic        fifo_select,
    input  wire logic [7:0]  addr,
    input  wire logic        host_data_oe,
    input  wire logic        dev_data_oe,
    input  wire logic [15:0] data_bus
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////////////////
    // Pin timing and drive ownership
    a_no_bus_fight: assert property (!(host_data_oe && dev_data_oe)) else $error("bus fight");
    a_rd_wr_apart: assert property (read_strobe_n || write_strobe_n) else $error("rd wr overlap");
    a_rd_low_min: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*8])
        else $error("read strobe short");
    a_rd_high_min: assert property ($rose(read_strobe_n) |-> read_strobe_n [*4])
        else $error("read gap short");
    a_wr_then_rd: assert property ($rose(write_strobe_n) |-> read_strobe_n [*4])
        else $error("read too soon after write");
    a_dev_answers: assert property ($fell(read_strobe_n) && !chip_select_n
        |-> ##[2:6] dev_data_oe) else $error("device silent");
    a_host_quiet: assert property (!read_strobe_n |-> !host_data_oe) else $error("host drives");
    // Test register value once the cycle has settled
    a_test_value: assert property (!read_strobe_n && $past(read_strobe_n, 3) == 1'b0
        && dev_data_oe && !fifo_select && addr == hawg_pkg::OFS_BYTE_TEST
        |-> data_bus == hawg_pkg::BYTE_TEST_VAL) else $error("test value wrong");
endmodule : hawg_checker

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        cv = 1'b0, cw = 1'b0, cf = 1'b0, rx_disc = 1'b0;
    logic [7:0]  ca = 8'h00;
    logic [15:0] cd = 16'h0000, rdat, q;
    logic        rdy, rv, rd_q = 1'b1, stall, pop;
    logic [15:0] rxw = 16'h0000, txw;
    int          num_errors = 0, checks_done = 0, idle = 0, gap = 0, nst = 0, npop = 0;
    hawg_if bus ();
    hawg_host_end hawg_host_end_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus(bus),
        .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_fifo_in(cf), .cmd_addr_in(ca),
        .cmd_wdata_in(cd), .cmd_ready_out(rdy), .rsp_valid_out(rv), .rsp_data_out(rdat),
        .guard_stall_out(stall));
    // Receive and transmit sides idle except for discard pulses and the receive word
    hawg_device_end hawg_device_end_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus(bus),
        .rx_push_in(1'b0), .rx_word_in(rxw), .rx_status_in(16'h0000),
        .rx_discard_in(rx_disc), .rx_pop_out(pop), .rx_status_pop_out(), .tx_word_valid_out(),
        .tx_word_out(txw), .tx_drain_in(1'b0), .tx_status_push_in(1'b0), .tx_status_in(16'h0000));
    hawg_checker hawg_checker_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .chip_select_n(bus.chip_select_n), .read_strobe_n(bus.read_strobe_n),
        .write_strobe_n(bus.write_strobe_n), .fifo_select(bus.fifo_select), .addr(bus.addr),
        .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe), .data_bus(bus.data_bus));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // Idle cycles on the pins before each read strobe fall
    always @(posedge ref_clk_in) begin
        rd_q <= bus.read_strobe_n;
        idle <= (bus.read_strobe_n && bus.write_strobe_n) ? idle + 1 : 0;
        if (rd_q && !bus.read_strobe_n) gap <= idle;
        if (stall) nst <= nst + 1;                  // Guard stall cycles seen
        if (pop) npop <= npop + 1;                  // Receive pops seen
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // One command through the user port; bounded waits cut a hang short
    task automatic xfer(input logic w, input logic f, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 300) begin @(negedge ref_clk_in); n++; end
        @(posedge ref_clk_in);
        {cv, cw, cf, ca, cd} <= {1'b1, w, f, a, d};
        @(posedge ref_clk_in);
        cv <= 1'b0;
        while (!w && rv !== 1'b1 && n < 300) begin @(negedge ref_clk_in); n++; end
        if (n >= 300) begin num_errors++; report_and_stop(); end
        q = rdat;
        @(negedge ref_clk_in);
    endtask : xfer
    // Read after write: idle cycles on the pins; callers compare the value
    task automatic raw(input logic [7:0] a, input int cyc);
        xfer(1'b1, 1'b0, hawg_pkg::OFS_HARDWARE_CONFIG_REG, 16'h5AA5);
        xfer(1'b0, 1'b0, a, 16'h0000);
        cmp("gap", 16'h0001, {15'h0000, gap >= cyc});
    endtask : raw
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        xfer(1'b0, 1'b0, hawg_pkg::OFS_BYTE_TEST, 16'h0000);
        cmp("test", hawg_pkg::BYTE_TEST_VAL, q);
        raw(hawg_pkg::OFS_HARDWARE_CONFIG_REG, 3);
        cmp("hw", 16'h5AA5, q);
        raw(hawg_pkg::OFS_INT_EN, 3);
        raw(hawg_pkg::OFS_INT_STAT, 5);
        raw(hawg_pkg::OFS_IRQ_CFG, 7);
        raw(hawg_pkg::OFS_FREE_CNT, 9);
        raw(hawg_pkg::OFS_PWR_CTRL, 16);
        cmp("stall", 16'h0001, {15'h0000, nst > 0});
        raw(hawg_pkg::OFS_IDENT, 0);
        cmp("ident", hawg_pkg::IDENT_VAL, q);
        $display("write-read waits done");
        xfer(1'b1, 1'b0, hawg_pkg::OFS_HARDWARE_CONFIG_REG, 16'h0001);
        @(posedge ref_clk_in) rxw <= 16'hC0DE;
        xfer(1'b0, 1'b1, 8'h04, 16'h0000);
        cmp("fifo gap", 16'h0001, {15'h0000, gap >= 16});
        cmp("fifo word", 16'hC0DE, q);
        cmp("fifo pops", 16'h0001, npop[15:0]);
        xfer(1'b1, 1'b0, hawg_pkg::OFS_TX_DATA, 16'hBEEF);
        xfer(1'b0, 1'b0, hawg_pkg::OFS_TX_INFO, 16'h0000);
        cmp("tx level", 16'h0001, q);
        cmp("tx word", 16'hBEEF, txw);
        @(posedge ref_clk_in) rx_disc <= 1'b1;
        @(posedge ref_clk_in) rx_disc <= 1'b0;
        xfer(1'b0, 1'b0, hawg_pkg::OFS_RX_DISC, 16'h0000);
        cmp("discard", 16'h0001, q);
        xfer(1'b0, 1'b0, hawg_pkg::OFS_RX_DISC, 16'h0000);
        cmp("discard gap", 16'h0001, {15'h0000, gap >= 9});
        cmp("discard clr", 16'h0000, q);
        $display("side effect reads done");
        report_and_stop();
    end
endmodule : tb_top
